// file: bench/dma_bandwidth_regulation_arbiter_test.sv
// self-checking bench for the dma bandwidth regulation arbiter
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  error_cnt++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module dma_bandwidth_regulation_arbiter_test;
  logic i_clk, i_sys_rst, i_wr_en, i_rd_en, rd_rdy, wr_rdy, o_irq, slow;
  logic [7:0] i_addr;
  logic [31:0] i_wr_data, o_rd_data;
  logic [7:0] i_rd_req, i_wr_req, o_rd_gnt, o_wr_gnt;
  logic [7:0] i_wu_active, i_wu_done, i_wrap;
  int error_cnt, compares;
  int rd_cnt [8];
  int wr_cnt [8];

  dma_bandwidth_regulation_arbiter uut (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_rd_req(i_rd_req), .i_wr_req(i_wr_req), .i_rd_xbar_ready(rd_rdy),
    .i_wr_xbar_ready(wr_rdy), .o_rd_gnt(o_rd_gnt), .o_wr_gnt(o_wr_gnt),
    .i_wu_active(i_wu_active), .i_wu_done(i_wu_done), .i_wrap(i_wrap),
    .o_irq(o_irq));
  xbar_model far_end (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_slow(slow),
    .o_rd_ready(rd_rdy), .o_wr_ready(wr_rdy));

  task tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one cycle write strobe; the next call lets an edge pass first
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] ex);
    @(posedge i_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1;
    `CHK(nm, ex, o_rd_data)
  endtask

  // counts grants per channel until the total is reached, bounded
  task automatic count_gnt(input int total);
    int n;
    int guard;
    n = 0;
    guard = 0;
    for (int c = 0; c < 8; c++) begin
      rd_cnt[c] = 0;
      wr_cnt[c] = 0;
    end
    while (n < total && guard < 300) begin
      @(posedge i_clk);
      #1;
      guard++;
      for (int c = 0; c < 8; c++) begin
        rd_cnt[c] += int'(o_rd_gnt[c] === 1'b1);
        wr_cnt[c] += int'(o_wr_gnt[c] === 1'b1);
        n += int'(o_rd_gnt[c] === 1'b1) + int'(o_wr_gnt[c] === 1'b1);
      end
    end
    `CHK("grant_total", total, n)
  endtask

  task automatic reset_values;
    rd_chk("rd_slot0", dma_bw_pkg::RD_SLOT_BASE,
           dma_bw_pkg::SLOT_MAP_RST0);
    rd_chk("rd_slot1", dma_bw_pkg::RD_SLOT_BASE + 8'h01,
           dma_bw_pkg::SLOT_MAP_RST1);
    rd_chk("wr_slot0", dma_bw_pkg::WR_SLOT_BASE,
           dma_bw_pkg::SLOT_MAP_RST0);
    rd_chk("wr_slot1", dma_bw_pkg::WR_SLOT_BASE + 8'h01,
           dma_bw_pkg::SLOT_MAP_RST1);
    rd_chk("status", dma_bw_pkg::IRQ_STATUS, 32'h00000000);
    rd_chk("clear_reg", dma_bw_pkg::IRQ_CLEAR, 32'h00000000);
    rd_chk("unmapped", 8'h30, 32'h00000000);
  endtask

  // only channel 0 requests, so idle slots must be skipped
  task automatic spacing_case(input logic [15:0] sp, input int gap);
    int last;
    int cnt;
    last = -1;
    cnt = 0;
    wr(dma_bw_pkg::SPACING_BASE, {16'h0000, sp});
    rd_chk("spacing", dma_bw_pkg::SPACING_BASE, {16'h0000, sp});
    @(posedge i_clk);
    i_rd_req <= 8'h01;
    for (int t = 0; t < 40; t++) begin
      @(posedge i_clk);
      #1;
      if (o_rd_gnt === 8'h01) begin
        if (last >= 0)
          `CHK("grant_gap", gap, t - last)
        last = t;
        cnt++;
      end
    end
    `CHK("grant_seen", gap != 0, cnt != 0)
    @(posedge i_clk);
    i_rd_req <= 8'h00;
    repeat (3) @(posedge i_clk);
  endtask

  // sixteen grants visit every slot once whatever the pointer start
  task automatic slot_case;
    @(posedge i_clk);
    slow <= 1'b1;
    i_rd_req <= 8'hff;
    count_gnt(16);
    for (int c = 0; c < 8; c++) begin
      `CHK("rd_share", 2, rd_cnt[c])
    end
    @(posedge i_clk);
    i_rd_req <= 8'h00;
    repeat (3) @(posedge i_clk);
    // channel 6 takes both slots of channel 7
    wr(dma_bw_pkg::RD_SLOT_BASE + 8'h01, 32'h66665544);
    @(posedge i_clk);
    i_rd_req <= 8'hff;
    count_gnt(16);
    for (int c = 0; c < 8; c++) begin
      `CHK("rd_share2", (c == 6) ? 4 : (c == 7) ? 0 : 2, rd_cnt[c])
    end
    @(posedge i_clk);
    i_rd_req <= 8'h00;
    slow <= 1'b0;
    // let the last read grant drain so it is not counted as a write
    repeat (3) @(posedge i_clk);
    i_wr_req <= 8'hff;
    count_gnt(16);
    for (int c = 0; c < 8; c++) begin
      `CHK("wr_share", 2, wr_cnt[c])
    end
    @(posedge i_clk);
    i_wr_req <= 8'h00;
    repeat (3) @(posedge i_clk);
  endtask

  task automatic monitor_case;
    wr(dma_bw_pkg::RELOAD_BASE + 8'h01, 32'h00000005);
    wr(dma_bw_pkg::IRQ_ENABLE, 32'h00000002);
    @(posedge i_clk);
    i_wu_active <= 8'h02;
    wr(dma_bw_pkg::CFG_BASE + 8'h01, 32'h00000000);
    repeat (10) @(posedge i_clk);
    rd_chk("status", dma_bw_pkg::IRQ_STATUS, 32'h00000002);
    rd_chk("cause", dma_bw_pkg::ERR_CAUSE, 32'h00000060);
    `CHK("irq_on", 1'b1, o_irq)
    @(posedge i_clk);
    i_rd_req <= 8'h02;
    count_gnt(4);
    @(posedge i_clk);
    i_rd_req <= 8'h00;
    rd_chk("cur_zero", dma_bw_pkg::CURRENT_BASE + 8'h01, 32'h0);
    wr(dma_bw_pkg::IRQ_ENABLE, 32'h00000000);
    @(posedge i_clk);
    #1;
    `CHK("irq_mask", 1'b0, o_irq)
    @(posedge i_clk);
    i_wu_active <= 8'h00;
    @(posedge i_clk);
    i_wu_done <= 8'h02;
    @(posedge i_clk);
    i_wu_done <= 8'h00;
    rd_chk("cur_done", dma_bw_pkg::CURRENT_BASE + 8'h01, 32'h5);
    // active across exactly two edges
    @(posedge i_clk);
    i_wu_active <= 8'h02;
    repeat (2) @(posedge i_clk);
    i_wu_active <= 8'h00;
    rd_chk("cur_dec", dma_bw_pkg::CURRENT_BASE + 8'h01, 32'h3);
    @(posedge i_clk);
    i_wrap <= 8'h02;
    @(posedge i_clk);
    i_wrap <= 8'h00;
    rd_chk("cur_wrap", dma_bw_pkg::CURRENT_BASE + 8'h01, 32'h5);
    wr(dma_bw_pkg::IRQ_CLEAR, 32'h00000002);
    rd_chk("st_clr", dma_bw_pkg::IRQ_STATUS, 32'h00000000);
    rd_chk("cause_clr", dma_bw_pkg::ERR_CAUSE, 32'h00000000);
  endtask

  // a zero reload must never expire however long the unit runs
  task automatic reload_zero_case;
    wr(dma_bw_pkg::RELOAD_BASE + 8'h02, 32'h00000000);
    @(posedge i_clk);
    i_wu_active <= 8'h04;
    wr(dma_bw_pkg::CFG_BASE + 8'h02, 32'h00000000);
    repeat (20) @(posedge i_clk);
    rd_chk("no_expiry", dma_bw_pkg::IRQ_STATUS, 32'h00000000);
    @(posedge i_clk);
    i_wu_active <= 8'h00;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // the whole run needs well under two thousand cycles
  initial begin
    #60000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    error_cnt = 0;
    compares = 0;
    i_sys_rst = 1'b1;
    {i_wr_en, i_rd_en, slow} = 3'h0;
    i_addr = 8'h00;
    i_wr_data = 32'h00000000;
    {i_rd_req, i_wr_req, i_wu_active, i_wu_done, i_wrap} = 40'h0;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    reset_values();
    spacing_case(16'h0003, 3);
    spacing_case(16'h0008, 8);
    spacing_case(16'hffff, 0);
    spacing_case(16'h0000, 1);
    slot_case();
    monitor_case();
    reload_zero_case();
    tally_and_finish();
  end
endmodule

// file: bench/xbar_model.sv
// crossbar stand-in that accepts requests at once or every other cycle
`timescale 1ns/1ps
module xbar_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_slow,
  output logic o_rd_ready,
  output logic o_wr_ready
);
  logic phase_ff;

  // free running phase used to throttle acceptance when slow
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff;
    end
  end

  // read and write stall in opposite phases so both paths see back pressure
  assign o_rd_ready = ~i_slow | phase_ff;
  assign o_wr_ready = ~i_slow | ~phase_ff;
endmodule

// file: rtl/arb_if.sv
// request, slot table and grant signals between top and slot arbiter
`timescale 1ns/1ps
interface arb_if #(
  parameter int NUM_CH = 8,
  parameter int NUM_SLOTS = 16
);
  logic [NUM_CH-1:0] req;
  logic [NUM_SLOTS*dma_bw_pkg::SLOT_FLD_W-1:0] slots;
  logic ready;
  logic [NUM_CH-1:0] issue;
  logic [NUM_CH-1:0] gnt_ff;
  modport arb (input req, input slots, input ready,
               output issue, output gnt_ff);
  modport user (output req, output slots, output ready,
                input issue, input gnt_ff);
endinterface

// file: rtl/dma_bandwidth_regulation_arbiter.sv
// request spacing, work unit monitor and slot arbitration for dma channels
`timescale 1ns/1ps

// Behaviour
// - throughput capped by transfer size over spacing
// - spacing sets least cycles between requests
// - zero spacing allows back to back requests
// - all ones spacing stops further requests
// - reload current count on config, end, wrap
// - current count decrements while work unit active
// - expiry sets error flag, cause code six
// - expired count stays zero until reloaded
// - monitor expiry never halts the channel
// - zero reload count disables the monitor
// - channel to arbiter routing is static
// - each master port owns preassigned slots
// - round robin, read and write separate, write yields a channel to read
// - software may give slaves any slot count
// - sixteen slots, two per channel default
// - slotless channel is never granted
module dma_bandwidth_regulation_arbiter #(
  parameter int NUM_CH = dma_bw_pkg::NUM_CH,
  parameter int NUM_SLOTS = dma_bw_pkg::NUM_SLOTS,
  parameter int SPACING_W = dma_bw_pkg::SPACING_W,
  parameter int MON_W = dma_bw_pkg::MON_W
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [dma_bw_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dma_bw_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [dma_bw_pkg::DATA_W-1:0] o_rd_data,
  input wire logic [NUM_CH-1:0] i_rd_req,
  input wire logic [NUM_CH-1:0] i_wr_req,
  input wire logic i_rd_xbar_ready,
  input wire logic i_wr_xbar_ready,
  output logic [NUM_CH-1:0] o_rd_gnt,
  output logic [NUM_CH-1:0] o_wr_gnt,
  input wire logic [NUM_CH-1:0] i_wu_active,
  input wire logic [NUM_CH-1:0] i_wu_done,
  input wire logic [NUM_CH-1:0] i_wrap,
  output logic o_irq
);
  localparam int DW = dma_bw_pkg::DATA_W;
  localparam int AW = dma_bw_pkg::ADDR_W;
  localparam int CAW = dma_bw_pkg::CAUSE_W;
  localparam int SLOT_REGS = NUM_SLOTS / dma_bw_pkg::SLOTS_PER_REG;
  localparam logic [SPACING_W-1:0] STOP = '1;

  // the register map and slot field layout serve these ranges only
  if (NUM_CH < 1 || NUM_CH > (1 << dma_bw_pkg::SLOT_CH_W) ||
      NUM_CH * CAW > DW) begin : g_bad_ch
    $error("channel count not supported by the register map");
  end
  if (NUM_SLOTS != 8 && NUM_SLOTS != 16) begin : g_bad_slots
    $error("slot count must be 8 or 16");
  end
  if (SPACING_W < 2 || SPACING_W > DW || MON_W < 2 ||
      MON_W > DW) begin : g_bad_width
    $error("counter widths must fit one data word");
  end

  logic [SPACING_W-1:0] spacing_ff [NUM_CH];
  logic [MON_W-1:0] reload_ff [NUM_CH];
  logic [MON_W-1:0] cur_ff [NUM_CH];
  logic [dma_bw_pkg::CFG_W-1:0] cfg_ff [NUM_CH];
  logic [CAW-1:0] cause_ff [NUM_CH];
  logic [NUM_CH-1:0] status_ff;
  logic [NUM_CH-1:0] irq_en_ff;
  logic [NUM_CH-1:0] expire;
  logic [NUM_CH-1:0] reload_evt;
  logic [NUM_CH-1:0] elig;
  logic [NUM_CH-1:0] irq_clear;
  logic [DW-1:0] rd_slot_ff [SLOT_REGS];
  logic [DW-1:0] wr_slot_ff [SLOT_REGS];
  logic [NUM_CH*CAW-1:0] cause_flat;
  logic [DW-1:0] nxt_rd_data;
  logic [DW-1:0] rd_data_ff;
  logic irq_ff;

  arb_if #(.NUM_CH(NUM_CH), .NUM_SLOTS(NUM_SLOTS)) rd_if();
  arb_if #(.NUM_CH(NUM_CH), .NUM_SLOTS(NUM_SLOTS)) wr_if();

  // fixed routing: channel n always sits on request bit n of both
  // arbiters; the write side yields when the read side takes the channel
  // this cycle, so a channel never issues two requests at once
  assign rd_if.req = i_rd_req & elig;
  assign wr_if.req = i_wr_req & elig & ~rd_if.issue;
  assign rd_if.ready = i_rd_xbar_ready;
  assign wr_if.ready = i_wr_xbar_ready;

  // read and write channels arbitrate concurrently
  slot_rr_arbiter #(.NUM_CH(NUM_CH), .NUM_SLOTS(NUM_SLOTS)) u_rd_arb (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .bus(rd_if.arb)
  );
  slot_rr_arbiter #(.NUM_CH(NUM_CH), .NUM_SLOTS(NUM_SLOTS)) u_wr_arb (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .bus(wr_if.arb)
  );

  assign o_rd_gnt = rd_if.gnt_ff;
  assign o_wr_gnt = wr_if.gnt_ff;
  assign o_rd_data = rd_data_ff;
  assign o_irq = irq_ff;

  // slot tables: reset gives two consecutive slots to each channel,
  // software may rewrite any slot to any channel or mark it empty
  for (genvar r = 0; r < SLOT_REGS; r++) begin : g_slot
    localparam logic [DW-1:0] RST_VAL = (r == 0) ?
      dma_bw_pkg::SLOT_MAP_RST0 : dma_bw_pkg::SLOT_MAP_RST1;
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        rd_slot_ff[r] <= RST_VAL;
        wr_slot_ff[r] <= RST_VAL;
      end else if (i_wr_en) begin
        if (i_addr == dma_bw_pkg::RD_SLOT_BASE + AW'(r)) begin
          rd_slot_ff[r] <= i_wr_data;
        end
        if (i_addr == dma_bw_pkg::WR_SLOT_BASE + AW'(r)) begin
          wr_slot_ff[r] <= i_wr_data;
        end
      end
    end
    assign rd_if.slots[r*DW +: DW] = rd_slot_ff[r];
    assign wr_if.slots[r*DW +: DW] = wr_slot_ff[r];
  end

  // per channel: configuration, spacing limiter and work unit monitor
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic cfg_wr;
    assign cfg_wr = i_wr_en && (i_addr == dma_bw_pkg::CFG_BASE + AW'(c));

    // software registers of the channel
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        spacing_ff[c] <= '0;
        reload_ff[c] <= '0;
        cfg_ff[c] <= '0;
      end else if (i_wr_en) begin
        if (i_addr == dma_bw_pkg::SPACING_BASE + AW'(c)) begin
          spacing_ff[c] <= i_wr_data[SPACING_W-1:0];
        end
        if (i_addr == dma_bw_pkg::RELOAD_BASE + AW'(c)) begin
          reload_ff[c] <= i_wr_data[MON_W-1:0];
        end
        if (cfg_wr) begin
          cfg_ff[c] <= i_wr_data[dma_bw_pkg::CFG_W-1:0];
        end
      end
    end

    // a grant on either direction starts the spacing gap
    rate_limiter #(.SPACING_W(SPACING_W)) u_lim (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_spacing(spacing_ff[c]),
      .i_issued(rd_if.issue[c] | wr_if.issue[c]),
      .o_eligible(elig[c])
    );

    // reload beats decrement, so a work unit ending on the last count
    // never reports an expiry
    assign reload_evt[c] = cfg_wr | i_wu_done[c] | i_wrap[c];
    assign expire[c] = i_wu_active[c] && !reload_evt[c] &&
                       reload_ff[c] != '0 &&
                       cur_ff[c] == MON_W'(1);

    // current count: load, count down while active, park at zero
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        cur_ff[c] <= '0;
      end else if (reload_evt[c]) begin
        cur_ff[c] <= reload_ff[c];
      end else if (i_wu_active[c] && cur_ff[c] != '0) begin
        cur_ff[c] <= cur_ff[c] - 1'b1;
      end
    end

    // sticky flag; a set in the clearing cycle wins. the expiry only
    // reports: it feeds neither the limiter nor the arbiters
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        status_ff[c] <= 1'b0;
        cause_ff[c] <= '0;
      end else if (expire[c]) begin
        status_ff[c] <= 1'b1;
        cause_ff[c] <= dma_bw_pkg::CAUSE_MONITOR;
      end else if (irq_clear[c]) begin
        status_ff[c] <= 1'b0;
        cause_ff[c] <= '0;
      end
    end
    assign cause_flat[c*CAW +: CAW] = cause_ff[c];
  end

  // write-only clear register: ones clear the matching status bits
  assign irq_clear = (i_wr_en && i_addr == dma_bw_pkg::IRQ_CLEAR) ?
                     i_wr_data[NUM_CH-1:0] : '0;

  // interrupt enable register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_en_ff <= '0;
    end else if (i_wr_en && i_addr == dma_bw_pkg::IRQ_ENABLE) begin
      irq_en_ff <= i_wr_data[NUM_CH-1:0];
    end
  end

  // level interrupt, one cycle behind the status flags
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & irq_en_ff);
    end
  end

  // read decode; unmapped and write-only words read as zero
  always_comb begin
    nxt_rd_data = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if (i_addr == dma_bw_pkg::SPACING_BASE + AW'(c)) begin
        nxt_rd_data = DW'(spacing_ff[c]);
      end
      if (i_addr == dma_bw_pkg::RELOAD_BASE + AW'(c)) begin
        nxt_rd_data = DW'(reload_ff[c]);
      end
      if (i_addr == dma_bw_pkg::CURRENT_BASE + AW'(c)) begin
        nxt_rd_data = DW'(cur_ff[c]);
      end
      if (i_addr == dma_bw_pkg::CFG_BASE + AW'(c)) begin
        nxt_rd_data = DW'(cfg_ff[c]);
      end
    end
    for (int r = 0; r < SLOT_REGS; r++) begin
      if (i_addr == dma_bw_pkg::RD_SLOT_BASE + AW'(r)) begin
        nxt_rd_data = rd_slot_ff[r];
      end
      if (i_addr == dma_bw_pkg::WR_SLOT_BASE + AW'(r)) begin
        nxt_rd_data = wr_slot_ff[r];
      end
    end
    if (i_addr == dma_bw_pkg::IRQ_STATUS) begin
      nxt_rd_data = DW'(status_ff);
    end
    if (i_addr == dma_bw_pkg::IRQ_ENABLE) begin
      nxt_rd_data = DW'(irq_en_ff);
    end
    if (i_addr == dma_bw_pkg::ERR_CAUSE) begin
      nxt_rd_data = DW'(cause_flat);
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= i_rd_en ? nxt_rd_data : '0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // read data must fall back to zero once its one cycle has passed,
  // otherwise a stale word could be taken for a later answer
  a_rd_data_idle: assert property (
    !i_rd_en |=> rd_data_ff == '0)
    else $error("read data stood longer than one cycle");

  // the interrupt line follows the enabled flags one cycle late
  a_irq_level: assert property (
    i_rd_en || !i_rd_en |=>
    irq_ff == |($past(status_ff) & $past(irq_en_ff)))
    else $error("interrupt line does not follow enabled flags");

  // per channel checks of the monitor, the flags and the limiter
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
    sequence s_expire_seen;
      expire[c] ##1 status_ff[c];
    endsequence

    a_mon_reload: assert property (
      reload_evt[c] |=> cur_ff[c] == $past(reload_ff[c]))
      else $error("monitor count not reloaded");
    a_mon_count: assert property (
      i_wu_active[c] && !reload_evt[c] && cur_ff[c] != '0
      |=> cur_ff[c] == $past(cur_ff[c]) - 1'b1)
      else $error("monitor count did not step down by one");
    a_mon_idle: assert property (
      !i_wu_active[c] && !reload_evt[c] |=> $stable(cur_ff[c]))
      else $error("monitor count moved while no work unit active");
    a_expire_flag: assert property (
      s_expire_seen |-> cause_ff[c] == dma_bw_pkg::CAUSE_MONITOR
      ##1 irq_ff || !irq_en_ff[c])
      else $error("expiry did not flag cause six");
    a_zero_parks: assert property (
      cur_ff[c] == '0 && !reload_evt[c] |=> cur_ff[c] == '0)
      else $error("expired monitor count wrapped");
    // the flag may still stand from an earlier expiry, so only a rise
    // of the flag counts as a wrongly raised expiry
    a_mon_off: assert property (
      reload_ff[c] == '0 |-> !expire[c] ##1 !$rose(status_ff[c]))
      else $error("disabled monitor raised an expiry");
    a_stop_gnt: assert property (
      spacing_ff[c] == STOP |=> !o_rd_gnt[c] && !o_wr_gnt[c])
      else $error("grant while channel spacing is all ones");
    a_no_halt: assert property (
      expire[c] |-> elig[c] == ((spacing_ff[c] != STOP) &&
      g_ch[c].u_lim.gap_ff == '0))
      else $error("expiry disturbed request eligibility");
  end
endmodule

// file: rtl/dma_bw_pkg.sv
// shared constants for the dma bandwidth regulation arbiter
package dma_bw_pkg;
  // structural defaults
  localparam int NUM_CH = 8;
  localparam int NUM_SLOTS = 16;
  localparam int SPACING_W = 16;
  localparam int MON_W = 32;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CFG_W = 8;
  localparam int CAUSE_W = 4;
  // slot field: channel select in low bits, top bit marks an empty slot
  localparam int SLOT_FLD_W = 4;
  localparam int SLOT_CH_W = 3;
  localparam int SLOT_EMPTY_BIT = 3;
  localparam int SLOTS_PER_REG = 8;
  // register word offsets
  localparam logic [7:0] SPACING_BASE = 8'h00;
  localparam logic [7:0] RELOAD_BASE = 8'h08;
  localparam logic [7:0] CURRENT_BASE = 8'h10;
  localparam logic [7:0] CFG_BASE = 8'h18;
  localparam logic [7:0] IRQ_STATUS = 8'h20;
  localparam logic [7:0] IRQ_CLEAR = 8'h21;
  localparam logic [7:0] IRQ_ENABLE = 8'h22;
  localparam logic [7:0] ERR_CAUSE = 8'h23;
  localparam logic [7:0] RD_SLOT_BASE = 8'h24;
  localparam logic [7:0] WR_SLOT_BASE = 8'h26;
  // reset values and codes
  localparam logic [3:0] CAUSE_MONITOR = 4'h6;
  localparam logic [31:0] SLOT_MAP_RST0 = 32'h33221100;
  localparam logic [31:0] SLOT_MAP_RST1 = 32'h77665544;
endpackage

// file: rtl/rate_limiter.sv
// per-channel request spacing limiter
`timescale 1ns/1ps
module rate_limiter #(
  parameter int SPACING_W = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [SPACING_W-1:0] i_spacing,
  input wire logic i_issued,
  output logic o_eligible
);
  localparam logic [SPACING_W-1:0] STOP = '1;

  logic [SPACING_W-1:0] gap_ff;
  logic [SPACING_W:0] since_ff;
  logic [SPACING_W-1:0] last_sp_ff;
  logic seen_ff;

  // all ones parks the channel; otherwise wait for the gap to drain
  assign o_eligible = (i_spacing != STOP) && (gap_ff == '0);

  // an issue loads spacing-1 so the next issue lands spacing cycles on
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      gap_ff <= '0;
    end else if (i_issued) begin
      gap_ff <= (i_spacing == '0) ? '0 : i_spacing - 1'b1;
    end else if (gap_ff != '0) begin
      gap_ff <= gap_ff - 1'b1;
    end
  end

  // helper for checking: cycles since the previous issue
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      since_ff <= '0;
      seen_ff <= 1'b0;
      last_sp_ff <= '0;
    end else if (i_issued) begin
      since_ff <= (SPACING_W+1)'(1);
      seen_ff <= 1'b1;
      last_sp_ff <= i_spacing;
    end else if (since_ff != '1) begin
      since_ff <= since_ff + 1'b1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_issue_at_zero;
    i_issued && i_spacing == '0 ##1 i_spacing == '0;
  endsequence

  a_spacing_gap: assert property (
    i_issued && seen_ff |-> since_ff >= {1'b0, last_sp_ff})
    else $error("requests issued closer than the programmed spacing");
  a_zero_back: assert property (
    s_issue_at_zero |-> o_eligible)
    else $error("zero spacing did not allow back to back requests");
  a_stop_hold: assert property (
    i_spacing == STOP |-> !o_eligible ##1 (i_spacing != STOP || !i_issued))
    else $error("request issued while spacing is all ones");
endmodule

// file: rtl/slot_rr_arbiter.sv
// slot based round robin arbiter for one crossbar master port channel
`timescale 1ns/1ps
module slot_rr_arbiter #(
  parameter int NUM_CH = 8,
  parameter int NUM_SLOTS = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  arb_if.arb bus
);
  localparam int PTR_W = $clog2(NUM_SLOTS);
  localparam int FW = dma_bw_pkg::SLOT_FLD_W;
  localparam int CW = dma_bw_pkg::SLOT_CH_W;

  if ((NUM_SLOTS & (NUM_SLOTS - 1)) != 0) begin : g_bad_slots
    $error("slot count must be a power of two");
  end

  logic [PTR_W-1:0] ptr_ff;
  logic [PTR_W-1:0] nxt_ptr;
  logic [NUM_CH-1:0] nxt_issue;
  logic [NUM_CH-1:0] owned;

  // walk slots from the pointer; idle slots are skipped in this cycle
  always_comb begin
    logic found;
    logic [PTR_W-1:0] idx;
    logic [FW-1:0] fld;
    found = 1'b0;
    idx = '0;
    fld = '0;
    nxt_issue = '0;
    nxt_ptr = ptr_ff;
    for (int k = 0; k < NUM_SLOTS; k++) begin
      idx = ptr_ff + PTR_W'(k);
      fld = bus.slots[int'(idx)*FW +: FW];
      if (!found && bus.ready && !fld[dma_bw_pkg::SLOT_EMPTY_BIT] &&
          int'(fld[CW-1:0]) < NUM_CH && bus.req[fld[CW-1:0]]) begin
        found = 1'b1;
        nxt_issue[fld[CW-1:0]] = 1'b1;
        nxt_ptr = idx + PTR_W'(1);
      end
    end
  end

  assign bus.issue = nxt_issue;

  // grant is registered so the top output comes from a flop
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ptr_ff <= '0;
      bus.gnt_ff <= '0;
    end else begin
      ptr_ff <= nxt_ptr;
      bus.gnt_ff <= nxt_issue;
    end
  end

  // helper: channels that hold at least one slot
  always_comb begin
    owned = '0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (!bus.slots[s*FW + dma_bw_pkg::SLOT_EMPTY_BIT] &&
          int'(bus.slots[s*FW +: CW]) < NUM_CH) begin
        owned[bus.slots[s*FW +: CW]] = 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_single_grant: assert property ($onehot0(bus.issue))
    else $error("more than one channel granted in a cycle");
  a_skip_idle: assert property (
    bus.ready && |(bus.req & owned) |-> |bus.issue ##1 |bus.gnt_ff)
    else $error("pending request with slots was not granted");
  a_no_slot_grant: assert property ((bus.issue & ~owned) == '0)
    else $error("channel without slots received a grant");
endmodule
